// [logic/sfr_space_decode_core_regs.sv]
/*
  Decoder for the special-register window and the core register file.
  Assumes the CPU data path on clk_sys issues one access per cycle, with
  byte addresses; peripheral groups answer reads combinationally.
*/
`timescale 1ns/1ps
`default_nettype none

// What this block does
// R1: Byte addresses 0x0000 to 0x07ff are decoded as the special-register window.
// R2: A read of a window address with no register behind it returns zero.
// R3: The window is split into 32-byte regions, each marked implemented or empty.
// R4: Core registers are served here and every other group is served by its own module.
// R5: Empty regions hold nothing and implemented regions other than the core-only regions 0 and 1 go to the listed module groups.
// R6: Registers with a printed zero reset clear on reset, undefined ones keep their value.
module sfr_space_decode_core_regs (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // CPU data path
  input  wire logic        rd_en,
  input  wire logic        wr_en,
  input  wire logic        byte_mode,
  input  wire logic [15:0] addr,
  input  wire logic [15:0] wdata,
  output logic      [15:0] rdata,
  output logic             rd_valid,
  output logic             addr_error,
  // Hardware-owned status input
  input  wire logic        ipl3_in,
  // Peripheral groups
  output logic             periph_sel,
  output logic             periph_wr,
  output logic             periph_byte,
  output logic      [10:0] periph_addr,
  output logic      [5:0]  periph_region,
  output logic      [15:0] periph_wdata,
  input  wire logic [15:0] periph_rdata,
  // Core register view
  output logic             psv_enable,
  output logic      [15:0] working_reg0,
  output logic      [15:0] cpu_status
);

  // ****************************************************************
  // Decode helpers
  // ****************************************************************

  localparam int IDX_W_L = sfr_space_pkg::IDX_W;

  // Finds the core register slot at a word address
  function automatic logic [IDX_W_L:0] core_lookup(input logic [15:0] a);
    logic [IDX_W_L:0] res;
    res = '0;
    for (int i = 0; i < sfr_space_pkg::CORE_COUNT; i++) begin
      if ({a[15:1], 1'b0} == sfr_space_pkg::CORE_OFFSET[i]) begin
        res = {1'b1, i[IDX_W_L-1:0]};
      end
    end
    return res;
  endfunction : core_lookup

  // True for a region that belongs to a peripheral group; core-only
  // regions are kept away so their holes read zero instead of group data
  function automatic logic periph_region_hit(input logic [5:0] r);
    return sfr_space_pkg::REGION_MAP[r] && !sfr_space_pkg::CORE_ONLY_MAP[r];
  endfunction : periph_region_hit

  logic                 in_window;
  logic                 core_hit;
  logic [IDX_W_L-1:0]   core_idx;
  logic [5:0]           region;
  logic                 region_impl;
  logic                 misaligned;

  // Window, region and core decode for the current access
  always_comb begin
    in_window   = (addr >= sfr_space_pkg::WINDOW_FIRST) &&
                  (addr <= sfr_space_pkg::WINDOW_LAST); // R1
    region      = addr[10:5]; // R3
    region_impl = in_window && sfr_space_pkg::REGION_MAP[region]; // R3
    {core_hit, core_idx} = core_lookup(addr);
    misaligned  = !byte_mode && addr[0];
  end

  // ****************************************************************
  // Peripheral routing
  // ****************************************************************

  // Core slots win over the region map so a group never shadows them
  always_comb begin
    periph_sel    = (rd_en || wr_en) && !core_hit && region_impl && periph_region_hit(region) &&
                    !misaligned; // R4 R5
    periph_wr     = wr_en && periph_sel;
    periph_byte   = byte_mode;
    periph_addr   = addr[10:0];
    periph_region = region;
    periph_wdata  = wdata;
  end

  // ****************************************************************
  // Core register file
  // ****************************************************************
  logic [15:0] core_reg      [sfr_space_pkg::CORE_COUNT];
  logic [15:0] next_core_reg [sfr_space_pkg::CORE_COUNT];
  logic [15:0] lane_mask;

  // Byte writes touch only the lane the address picks; misaligned words drop
  always_comb begin
    lane_mask = byte_mode ? (addr[0] ? 16'hff00 : 16'h00ff) : 16'hffff;
    for (int i = 0; i < sfr_space_pkg::CORE_COUNT; i++) begin
      next_core_reg[i] = core_reg[i];
      if (wr_en && core_hit && !misaligned && (core_idx == i[IDX_W_L-1:0])) begin
        next_core_reg[i] = (core_reg[i] & ~(lane_mask & sfr_space_pkg::CORE_WMASK[i])) |
                           ((byte_mode ? {wdata[7:0], wdata[7:0]} : wdata) &
                            lane_mask & sfr_space_pkg::CORE_WMASK[i]); // R4
      end
    end
    // Priority bit 3 of the control word follows the interrupt logic
    next_core_reg[sfr_space_pkg::SLOT_CONTROL][sfr_space_pkg::CTRL_IPL3_BIT] = ipl3_in;
  end

  // Only registers with a defined reset value are cleared
  generate
    for (genvar g = 0; g < sfr_space_pkg::CORE_COUNT; g++) begin : g_core
      if (sfr_space_pkg::CORE_HAS_RESET[g]) begin : g_rst
        always_ff @(posedge clk_sys) begin
          if (srst) begin
            core_reg[g] <= sfr_space_pkg::CORE_RESET[g]; // R6
          end else begin
            core_reg[g] <= next_core_reg[g];
          end
        end
      end else begin : g_norst
        // Undefined at reset, so no reset term saves area
        always_ff @(posedge clk_sys) begin
          core_reg[g] <= next_core_reg[g]; // R6
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Read path
  // ****************************************************************
  logic [15:0] next_rdata;
  logic        next_rd_valid;
  logic        next_addr_error;
  logic [15:0] word_val;

  // Selects the source word, then the byte lane for byte reads
  always_comb begin
    word_val = 16'h0000; // R2
    if (core_hit) begin
      word_val = core_reg[core_idx] & sfr_space_pkg::CORE_RMASK[core_idx];
    end else if (region_impl && periph_region_hit(region)) begin
      word_val = periph_rdata; // R5
    end
    next_rdata = 16'h0000;
    if (rd_en && !misaligned) begin
      next_rdata = byte_mode ? {8'h00, (addr[0] ? word_val[15:8] : word_val[7:0])} : word_val;
    end
    next_rd_valid   = rd_en;
    next_addr_error = (rd_en || wr_en) && misaligned;
  end

  // Read data lands one cycle after the request
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata      <= 16'h0000;
      rd_valid   <= 1'b0;
      addr_error <= 1'b0;
    end else begin
      rdata      <= next_rdata;
      rd_valid   <= next_rd_valid;
      addr_error <= next_addr_error;
    end
  end

  // Register view for the rest of the core
  always_comb begin
    psv_enable   = core_reg[sfr_space_pkg::SLOT_CONTROL][sfr_space_pkg::CTRL_PSV_BIT];
    working_reg0 = core_reg[sfr_space_pkg::SLOT_WORKING_REGISTER_0];
    cpu_status   = core_reg[sfr_space_pkg::SLOT_STATUS];
  end

  // ****************************************************************
  // Checks
  // ****************************************************************

  a_window_bound: assert property (@(posedge clk_sys) disable iff (srst) // R1
    periph_sel |-> (addr[15:11] == 5'h00))
    else $error("peripheral select outside the register window");

  a_unmapped_zero: assert property (@(posedge clk_sys) disable iff (srst) // R2
    (rd_en && !core_hit && !region_impl) |=> (rd_valid && rdata == 16'h0000))
    else $error("unmapped read did not return zero");

  a_region_map: assert property (@(posedge clk_sys) disable iff (srst) // R3
    periph_sel |-> sfr_space_pkg::REGION_MAP[periph_region])
    else $error("peripheral selected in an empty region");

  a_group_route: assert property (@(posedge clk_sys) disable iff (srst) // R4
    (wr_en && core_hit && !misaligned && !byte_mode && core_idx == 5'd0)
      |=> (!$past(periph_sel) && working_reg0 == $past(wdata)))
    else $error("core write not kept in the core register");

  a_empty_region: assert property (@(posedge clk_sys) disable iff (srst) // R5
    (rd_en && in_window && !sfr_space_pkg::REGION_MAP[region] && !core_hit)
      |-> (!periph_sel ##1 rdata == 16'h0000))
    else $error("empty region produced data");

  a_reset_clear: assert property (@(posedge clk_sys) // R6
    srst |=> (working_reg0 == 16'h0000 && cpu_status == 16'h0000 && !psv_enable))
    else $error("register not cleared by reset");

  a_periph_data: assert property (@(posedge clk_sys) disable iff (srst) // R5
    (rd_en && periph_sel && !byte_mode) |=> (rdata == $past(periph_rdata)))
    else $error("peripheral read data not returned");

  // ****************************************************************
  // Checks on the window and the read answer
  // ****************************************************************

  // Anything past the window must never reach a group or return data, except the core slot at 0x8000
  a_outside_zero: assert property (@(posedge clk_sys) disable iff (srst) // R1
    (rd_en && !in_window && !core_hit) |=> (rdata == 16'h0000))
    else $error("read outside the window returned data");

  a_no_sel_outside: assert property (@(posedge clk_sys) disable iff (srst) // R1
    !in_window |-> !periph_sel)
    else $error("peripheral selected outside the window");

  // Every read gets exactly one answer, one cycle later
  a_read_pulse: assert property (@(posedge clk_sys) disable iff (srst) // R2
    rd_en |=> rd_valid)
    else $error("read not answered");

  a_no_spurious_valid: assert property (@(posedge clk_sys) disable iff (srst) // R2
    !rd_en |=> !rd_valid)
    else $error("answer without a read");

  // Idle cycles keep the read bus at zero so a stale word never leaks
  a_idle_rdata_zero: assert property (@(posedge clk_sys) disable iff (srst) // R2
    !rd_en |=> (rdata == 16'h0000))
    else $error("read data not cleared on an idle cycle");

  a_byte_read_upper: assert property (@(posedge clk_sys) disable iff (srst) // R2
    (rd_en && byte_mode) |=> (rdata[15:8] == 8'h00))
    else $error("byte read left the upper lane set");

  a_addr_error_pulse: assert property (@(posedge clk_sys) disable iff (srst) // R2
    ((rd_en || wr_en) && misaligned) |=> (addr_error && rdata == 16'h0000))
    else $error("misaligned word access not flagged");

  // ****************************************************************
  // Checks on regions and routing
  // ****************************************************************

  // Holes between core registers in the core-only regions 0 and 1 belong to no group and read zero
  a_core_only_hole: assert property (@(posedge clk_sys) disable iff (srst) // R3
    (rd_en && in_window && sfr_space_pkg::CORE_ONLY_MAP[region] && !core_hit) |=> (rdata == 16'h0000))
    else $error("hole in a core region returned data");

  a_region_field: assert property (@(posedge clk_sys) disable iff (srst) // R3
    periph_sel |-> (periph_region == addr[10:5]))
    else $error("region number does not follow the address");

  a_core_no_periph: assert property (@(posedge clk_sys) disable iff (srst) // R4
    core_hit |-> !periph_sel)
    else $error("core register access leaked to a group");

  a_periph_wr_only: assert property (@(posedge clk_sys) disable iff (srst) // R4
    periph_wr |-> (wr_en && periph_sel))
    else $error("group write without a selected write");

  a_impl_region_sel: assert property (@(posedge clk_sys) disable iff (srst) // R5
    (rd_en && in_window && periph_region_hit(region) && !core_hit && !misaligned) |-> periph_sel)
    else $error("implemented group region not selected");

  a_empty_no_sel: assert property (@(posedge clk_sys) disable iff (srst) // R5
    !sfr_space_pkg::REGION_MAP[region] |-> !periph_sel)
    else $error("group selected in an empty region");

  // ****************************************************************
  // Checks on the core register file
  // ****************************************************************

  // A full-word status write keeps only the implemented bits
  a_status_write: assert property (@(posedge clk_sys) disable iff (srst) // R4
    (wr_en && !byte_mode && addr == sfr_space_pkg::CORE_OFFSET[sfr_space_pkg::SLOT_STATUS])
      |=> (cpu_status == ($past(wdata) & sfr_space_pkg::CORE_WMASK[sfr_space_pkg::SLOT_STATUS])))
    else $error("status write not kept");

  a_status_upper: assert property (@(posedge clk_sys) disable iff (srst) // R4
    cpu_status[15:9] == 7'h00)
    else $error("unimplemented status bits set");

  // Byte write to the low lane must leave the high lane alone
  a_byte_lane_keep: assert property (@(posedge clk_sys) disable iff (srst) // R4
    (wr_en && byte_mode && addr == sfr_space_pkg::CORE_OFFSET[sfr_space_pkg::SLOT_WORKING_REGISTER_0])
      |=> (working_reg0[15:8] == $past(working_reg0[15:8])))
    else $error("byte write disturbed the other lane");

  // A misaligned word write must not land anywhere
  a_misaligned_drop: assert property (@(posedge clk_sys) disable iff (srst) // R4
    (wr_en && !byte_mode && addr[15:1] == 15'h0000 && addr[0]) |=> $stable(working_reg0))
    else $error("misaligned write changed a register");

  a_control_ipl3: assert property (@(posedge clk_sys) disable iff (srst) // R4
    1'b1 |=> (core_reg[sfr_space_pkg::SLOT_CONTROL][sfr_space_pkg::CTRL_IPL3_BIT] == $past(ipl3_in)))
    else $error("priority bit does not follow the interrupt logic");

  // ****************************************************************
  // Checks on reset
  // ****************************************************************

  a_reset_outputs: assert property (@(posedge clk_sys) // R6
    srst |=> (!rd_valid && !addr_error && rdata == 16'h0000))
    else $error("answer outputs not cleared by reset");

  // Each register with a printed reset value holds it after reset
  generate
    for (genvar g = 0; g < sfr_space_pkg::CORE_COUNT; g++) begin : g_rst_chk
      if (sfr_space_pkg::CORE_HAS_RESET[g]) begin : g_on
        a_slot_reset: assert property (@(posedge clk_sys) // R6
          srst |=> (core_reg[g] == sfr_space_pkg::CORE_RESET[g]))
          else $error("core register not at its reset value");
      end
    end
  endgenerate

endmodule : sfr_space_decode_core_regs

`default_nettype wire

// [logic/sfr_space_pkg.sv]
/*
  Constants for the special-register window decoder: window bounds, region
  map, core register offsets, reset values and field masks.
  Assumes a 16-bit byte-addressed data space and 16-bit registers.
*/
package sfr_space_pkg;

  // ****************************************************************
  // Window and regions
  // ****************************************************************
  localparam logic [15:0] WINDOW_FIRST = 16'h0000;
  localparam logic [15:0] WINDOW_LAST  = 16'h07ff;
  localparam int          REGION_BYTES = 32;
  localparam int          REGION_COUNT = 64;
  // One bit per 32-byte region, bit n covers bytes n*32 .. n*32+31
  localparam logic [63:0] REGION_MAP   = 64'h0c06_0000_0fcf_177f;
  // Regions that hold core registers only; their holes never reach a group
  localparam logic [63:0] CORE_ONLY_MAP = 64'h0000_0000_0000_0003;

  // ****************************************************************
  // Core registers
  // ****************************************************************
  localparam int CORE_COUNT = 25;
  localparam int IDX_W      = 5;

  localparam logic [15:0] CORE_OFFSET [CORE_COUNT] = '{
    16'h0000, 16'h0002, 16'h0004, 16'h0006, 16'h000a, 16'h000c, 16'h000e,
    16'h0010, 16'h0012, 16'h0014, 16'h0016, 16'h0018, 16'h001a, 16'h001c,
    16'h001e, 16'h0020, 16'h002e, 16'h0030, 16'h0032, 16'h0034, 16'h0036,
    16'h0042, 16'h0044, 16'h0052, 16'h8000};

  // Set where the register has a defined reset value
  localparam logic [CORE_COUNT-1:0] CORE_HAS_RESET = 25'h16f_7cff;

  localparam logic [15:0] CORE_RESET [CORE_COUNT] = '{default: 16'h0000};

  // Implemented bits (read mask)
  localparam logic [15:0] CORE_RMASK [CORE_COUNT] = '{
    16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff,
    16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff,
    16'hffff, 16'hffff, 16'hffff, 16'h007f, 16'h00ff, 16'h00ff, 16'hffff,
    16'h01ff, 16'h000c, 16'h3fff, 16'hffff};

  // Software-writable bits; control word priority bit is set by hardware
  localparam logic [15:0] CORE_WMASK [CORE_COUNT] = '{
    16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff,
    16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff,
    16'hffff, 16'hffff, 16'hffff, 16'h007f, 16'h00ff, 16'h00ff, 16'hffff,
    16'h01ff, 16'h0004, 16'h3fff, 16'hffff};

  // Slots of registers the block uses itself
  localparam int SLOT_WORKING_REGISTER_0   = 0;
  localparam int SLOT_STATUS  = 21;
  localparam int SLOT_CONTROL = 22;

  // Control word fields
  localparam int CTRL_PSV_BIT  = 2;
  localparam int CTRL_IPL3_BIT = 3;

endpackage : sfr_space_pkg

// [dv/periph_group_model.sv]
/*
  Model of the peripheral register groups behind the decoder.
  Assumes periph_rdata is sampled by the decoder in the request cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module periph_group_model (
  // Clock
  input  wire logic        clk_sys,
  // Decoder side
  input  wire logic        periph_sel,
  input  wire logic [10:0] periph_addr,
  output logic      [15:0] periph_rdata
);
  logic [15:0] junk = 16'h0f0f;
  // Unselected bus changes every cycle so a stale value never matches
  always_ff @(posedge clk_sys) begin
    junk <= junk + 16'h1357;
  end
  // Each group answers a fixed function of its byte address
  always_comb begin
    periph_rdata = periph_sel ? ({5'h00, periph_addr} ^ 16'ha5c3) : junk;
  end
endmodule : periph_group_model
`default_nettype wire

// [dv/tb_top.sv]
/*
  Self-checking bench for the register window decoder.
  Assumes the peripheral model answers combinationally.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk_sys = 1'b0, srst = 1'b1, rd_en = 1'b0, wr_en = 1'b0, byte_mode = 1'b0, ipl3_in = 1'b0;
  logic [15:0] addr = 16'h0000, wdata = 16'h0000, rdata, periph_rdata, working_reg0, cpu_status, periph_wdata;
  logic [15:0] got, a;
  logic [15:0] w [25];
  logic [10:0] periph_addr;
  logic [5:0]  periph_region;
  logic [6:0]  sel;
  logic        rd_valid, addr_error, periph_sel, periph_wr, periph_byte, psv_enable, err;
  logic [31:0] lfsr = 32'd90641;
  logic [15:0] pa [5] = '{16'h0100, 16'h0200, 16'h0640, 16'h0740, 16'h0056};
  int          n_fail = 0, n_tests = 0;

  sfr_space_decode_core_regs u_sfr_space_decode_core_regs (.clk_sys, .srst, .rd_en, .wr_en, .byte_mode,
    .addr, .wdata, .rdata, .rd_valid, .addr_error, .ipl3_in, .periph_sel, .periph_wr, .periph_byte,
    .periph_addr, .periph_region, .periph_wdata, .periph_rdata, .psv_enable, .working_reg0, .cpu_status);
  periph_group_model u_periph_group_model (.clk_sys, .periph_sel, .periph_addr, .periph_rdata);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h00000000);
  endfunction : step
  // Read-back of a core slot; the priority bit follows the hardware input
  function automatic logic [15:0] exp_core(input int k, input logic [15:0] d, input logic q);
    return (d & sfr_space_pkg::CORE_WMASK[k] & sfr_space_pkg::CORE_RMASK[k])
      | ((k == sfr_space_pkg::SLOT_CONTROL) ? {12'h000, q, 3'h0} : 16'h0000);
  endfunction : exp_core
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    n_tests++;
    if (seen !== want) begin
      n_fail++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check
  // One access; m is read, write, byte. Outputs are sampled once settled
  task automatic op(input logic [2:0] m, input logic [15:0] ad, input logic [15:0] d);
    @(posedge clk_sys);
    rd_en <= m[2];
    wr_en <= m[1];
    byte_mode <= m[0];
    addr <= ad;
    wdata <= d;
    #1 sel = {periph_sel, periph_region};
    @(posedge clk_sys);
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    #1 got = rdata;
    err = addr_error;
  endtask : op
  task automatic reset_check;
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    for (int k = 0; k < sfr_space_pkg::CORE_COUNT; k++) begin
      if (sfr_space_pkg::CORE_HAS_RESET[k]) begin
        op(3'b100, sfr_space_pkg::CORE_OFFSET[k], 16'h0000);
        check(got, exp_core(k, 16'h0000, ipl3_in));
      end
    end
  endtask : reset_check
  task automatic results;
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    reset_check();
    // Every core register with random data
    for (int k = 0; k < sfr_space_pkg::CORE_COUNT; k++) begin
      lfsr = step(lfsr);
      ipl3_in <= lfsr[16];
      w[k] = exp_core(k, lfsr[15:0], lfsr[16]);
      op(3'b010, sfr_space_pkg::CORE_OFFSET[k], lfsr[15:0]);
      op(3'b100, sfr_space_pkg::CORE_OFFSET[k], 16'h0000);
      check(got, w[k]);
      check({15'h0000, sel[6]}, 16'h0000);
    end
    check(working_reg0, w[0]);
    check(cpu_status, w[21]);
    check({15'h0000, psv_enable}, {15'h0000, w[22][2]});
    // Byte lanes and a dropped misaligned word write
    op(3'b010, 16'h0002, 16'h1234);
    op(3'b011, 16'h0003, 16'h00ab);
    op(3'b010, 16'h0003, 16'hffff);
    check({15'h0000, err}, 16'h0001);
    op(3'b100, 16'h0002, 16'h0000);
    check(got, 16'hab34);
    op(3'b101, 16'h0003, 16'h0000);
    check(got, 16'h00ab);
    // Holes in the core region and fully empty regions read zero
    for (int i = 0; i < 30; i++) begin
      lfsr = step(lfsr);
      a = (i < 2) ? (i ? 16'h0022 : 16'h0008) : {7'h02, lfsr[8:1], 1'b0};
      op(3'b100, a, 16'h0000);
      check(got, 16'h0000);
      check({15'h0000, sel[6]}, 16'h0000);
    end
    // Implemented peripheral regions go to their group
    for (int i = 0; i < 20; i++) begin
      lfsr = step(lfsr);
      a = pa[i % 5] | {11'h000, lfsr[3:0], 1'b0};
      op(3'b100, a, 16'h0000);
      check(got, {5'h00, a[10:0]} ^ 16'ha5c3);
      check({9'h000, sel}, {9'h000, 1'b1, a[10:5]});
    end
    op(3'b100, 16'h0c00, 16'h0000);
    check({15'h0000, sel[6]}, 16'h0000);
    reset_check();
    results();
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    results();
  end
endmodule : tb_top
`default_nettype wire
